// >>> logic/blr_regs.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`include "blr_defines.svh"
module blr_regs (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   output logic             irq,
   input  wire logic        ifs_expire,
   input  wire logic        desc_busy,
   input  wire logic        permit_busy,
   input  wire logic        decrypt_busy,
   input  wire logic        permit_result_need,
   input  wire logic        evt_prefetch_instant,
   input  wire logic        evt_first_busy,
   input  wire logic        sched_prefetch_instant,
   input  wire logic        sched_first_busy,
   input  wire logic        sched_entry_load,
   input  wire logic        sched_entry_offset,
   input  wire logic        sched_mem_deadline,
   input  wire logic        sched_mem_pending,
   input  wire logic        radio_mem_deadline,
   input  wire logic        radio_mem_pending,
   input  wire logic        packet_mem_deadline,
   input  wire logic        packet_mem_pending,
   input  wire logic        rx_block_rcvd,
   input  wire logic        tx_block_send,
   input  wire logic        encrypt_ready,
   input  wire logic        tx_start,
   input  wire logic        tx_end,
   input  wire logic        rx_start,
   input  wire logic        rx_end,
   input  wire logic        adv_enable,
   input  wire logic        adv_pkt_sent,
   output logic [31:0]      diag_profile,
   output logic [4:0]       radio_select_field,
   output logic [6:0]       round_trip_latency,
   output logic             radio_power_en,
   output logic             radio_tx_en,
   output logic             radio_rx_en,
   output logic             adv_slot,
   output logic [5:0]       adv_channel
);
   localparam int USW = $clog2(`BLR_US_CYC);

   blr_pkg::blr_err_t err_r;
   blr_pkg::blr_err_t err_nxt;
   blr_pkg::blr_err_t ev;
   blr_pkg::blr_err_t ist_r;
   blr_pkg::blr_err_t ist_nxt;
   blr_pkg::blr_err_t imask_r;
   blr_pkg::blr_err_t imask_nxt;
   logic [31:0]       prof_r;
   logic [31:0]       prof_nxt;
   logic [4:0]        rsel_r;
   logic [4:0]        rsel_nxt;
   logic [6:0]        rtrip_r;
   logic [6:0]        rtrip_nxt;
   logic [7:0]        rxup_r;
   logic [7:0]        rxup_nxt;
   logic [3:0]        txdn_r;
   logic [3:0]        txdn_nxt;
   logic [7:0]        txup_r;
   logic [7:0]        txup_nxt;
   logic [2:0]        map_r;
   logic [2:0]        map_nxt;
   logic [13:0]       advsp_r;
   logic [13:0]       advsp_nxt;
   logic [31:0]       rdata_r;
   logic [31:0]       rdata_nxt;
   logic              prev_ofs_r;
   logic              prev_ofs_nxt;
   logic              entry_seen_r;
   logic              entry_seen_nxt;
   logic [USW-1:0]    pre_r;
   logic [USW-1:0]    pre_nxt;
   logic              tick_r;
   logic              tick_nxt;

   // Register writes
   always_comb begin
      prof_nxt   = prof_r;
      rsel_nxt   = rsel_r;
      rtrip_nxt  = rtrip_r;
      rxup_nxt   = rxup_r;
      txdn_nxt   = txdn_r;
      txup_nxt   = txup_r;
      map_nxt    = map_r;
      advsp_nxt  = advsp_r;
      imask_nxt  = imask_r;
      if (wr) begin
         unique case (addr)
            `BLR_OFS_PROFILE:   prof_nxt = wdata;
            `BLR_OFS_IRQ_MASK:  imask_nxt = wdata[`BLR_ERR_W-1:0];
            `BLR_OFS_RADIO_SEL: rsel_nxt = wdata[`BLR_RSEL_MSB:`BLR_RSEL_LSB];
            `BLR_OFS_PWR_TIM: begin
               rtrip_nxt = wdata[`BLR_RTRIP_MSB:`BLR_RTRIP_LSB];
               rxup_nxt  = wdata[`BLR_RXUP_MSB:`BLR_RXUP_LSB];
               txdn_nxt  = wdata[`BLR_TXDN_MSB:`BLR_TXDN_LSB];
               txup_nxt  = wdata[`BLR_TXUP_MSB:`BLR_TXUP_LSB];
            end
            `BLR_OFS_ADV_MAP:   map_nxt = wdata[`BLR_MAP_MSB:0];
            `BLR_OFS_ADV_TIM:   advsp_nxt = wdata[`BLR_ADVSP_MSB:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prof_r   <= 32'h0000_0000;
         rsel_r   <= `BLR_RST_RSEL;
         rtrip_r  <= `BLR_RST_RTRIP;
         rxup_r   <= `BLR_RST_RXUP;
         txdn_r   <= `BLR_RST_TXDN;
         txup_r   <= `BLR_RST_TXUP;
         map_r    <= `BLR_RST_MAP;
         advsp_r  <= `BLR_RST_ADVSP;
         imask_r  <= '0;
      end else begin
         prof_r   <= prof_nxt;
         rsel_r   <= rsel_nxt;
         rtrip_r  <= rtrip_nxt;
         rxup_r   <= rxup_nxt;
         txdn_r   <= txdn_nxt;
         txup_r   <= txup_nxt;
         map_r    <= map_nxt;
         advsp_r  <= advsp_nxt;
         imask_r  <= imask_nxt;
      end
   end

   // Microsecond tick shared by all timers
   always_comb begin
      tick_nxt = (pre_r == USW'(`BLR_US_CYC - 1));
      pre_nxt  = tick_nxt ? '0 : pre_r + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pre_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         pre_r  <= pre_nxt;
         tick_r <= tick_nxt;
      end
   end

   // Radio power sequencer
   blr_pkg::blr_radio_e rad_r;
   blr_pkg::blr_radio_e rad_nxt;
   logic                ph_load;
   logic [7:0]          ph_val;
   logic                ph_done;

   always_comb begin
      rad_nxt = rad_r;
      ph_load = 1'b0;
      ph_val  = 8'h00;
      unique case (rad_r)
         blr_pkg::RAD_IDLE: begin
            if (tx_start) begin
               rad_nxt = blr_pkg::RAD_TX_UP;
               ph_load = 1'b1;
               ph_val  = txup_r;
            end else if (rx_start) begin
               rad_nxt = blr_pkg::RAD_RX_UP;
               ph_load = 1'b1;
               ph_val  = rxup_r;
            end
         end
         blr_pkg::RAD_TX_UP: if (ph_done) rad_nxt = blr_pkg::RAD_TX_ON;
         blr_pkg::RAD_TX_ON: begin
            if (tx_end) begin
               rad_nxt = blr_pkg::RAD_TX_DN;
               ph_load = 1'b1;
               ph_val  = {4'h0, txdn_r};
            end
         end
         blr_pkg::RAD_TX_DN: if (ph_done) rad_nxt = blr_pkg::RAD_IDLE;
         blr_pkg::RAD_RX_UP: if (ph_done) rad_nxt = blr_pkg::RAD_RX_ON;
         blr_pkg::RAD_RX_ON: if (rx_end) rad_nxt = blr_pkg::RAD_IDLE;
         default: rad_nxt = blr_pkg::RAD_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rad_r <= blr_pkg::RAD_IDLE;
      end else begin
         rad_r <= rad_nxt;
      end
   end

   blr_us_timer #(.W(8)) u_phase (
      .clk   (clk),
      .srst  (srst),
      .tick  (tick_r),
      .load  (ph_load),
      .value (ph_val),
      .busy  (),
      .done  (ph_done)
   );

   // Advertising scheduler and spacing check
   logic        adv_load;
   logic        adv_done;
   logic        adv_on_r;
   logic        adv_on_nxt;
   logic [1:0]  ch_r;
   logic [1:0]  ch_nxt;
   logic        slot_r;
   logic        slot_nxt;
   logic [13:0] gap_r;
   logic [13:0] gap_nxt;
   logic        gap_seen_r;
   logic        gap_seen_nxt;
   logic        adv_short;

   // Next enabled channel after the current one, wrapping
   function automatic logic [1:0] next_ch(input logic [1:0] cur, input logic [2:0] m);
      logic [1:0] pick;
      logic [1:0] c;
      pick = cur;
      for (int k = 3; k >= 1; k--) begin
         c = 2'((int'(cur) + k) % 3);
         if (m[c]) pick = c;
      end
      return pick;
   endfunction

   always_comb begin
      adv_on_nxt   = adv_enable;
      adv_load     = adv_enable && (!adv_on_r || adv_done);
      ch_nxt       = ch_r;
      slot_nxt     = 1'b0;
      gap_nxt      = gap_r;
      gap_seen_nxt = gap_seen_r;
      adv_short    = 1'b0;
      // Empty map produces no slots rather than a bogus channel
      if (adv_enable && adv_done && (map_r != 3'h0)) begin
         ch_nxt   = next_ch(ch_r, map_r);
         slot_nxt = 1'b1;
      end
      if (!adv_enable) begin
         ch_nxt       = 2'h2;
         gap_seen_nxt = 1'b0;
      end
      if (tick_r && (gap_r != 14'h3fff)) begin
         gap_nxt = gap_r + 1'b1;
      end
      if (adv_enable && adv_pkt_sent) begin
         adv_short    = gap_seen_r && (gap_r < advsp_r);
         gap_nxt      = 14'h0000;
         gap_seen_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         adv_on_r   <= 1'b0;
         ch_r       <= 2'h2;
         slot_r     <= 1'b0;
         gap_r      <= 14'h0000;
         gap_seen_r <= 1'b0;
      end else begin
         adv_on_r   <= adv_on_nxt;
         ch_r       <= ch_nxt;
         slot_r     <= slot_nxt;
         gap_r      <= gap_nxt;
         gap_seen_r <= gap_seen_nxt;
      end
   end

   blr_us_timer #(.W(14)) u_adv (
      .clk   (clk),
      .srst  (srst),
      .tick  (tick_r),
      .load  (adv_load),
      .value (advsp_r),
      .busy  (),
      .done  (adv_done)
   );

   // Error detection
   always_comb begin
      ev = '0;
      ev[`BLR_BIT_GAP_UNDER] = ifs_expire && (desc_busy || permit_busy || decrypt_busy);
      ev[`BLR_BIT_PERMIT]    = permit_result_need && permit_busy;
      ev[`BLR_BIT_EVT_PF]    = evt_prefetch_instant && evt_first_busy;
      ev[`BLR_BIT_SCH_PF]    = sched_prefetch_instant && sched_first_busy;
      ev[`BLR_BIT_SCH_ENTRY] = sched_entry_load && entry_seen_r && prev_ofs_r && !sched_entry_offset;
      ev[`BLR_BIT_SCH_MEM]   = sched_mem_deadline && sched_mem_pending;
      ev[`BLR_BIT_RAD_MEM]   = radio_mem_deadline && radio_mem_pending;
      ev[`BLR_BIT_PKT_MEM]   = packet_mem_deadline && packet_mem_pending;
      ev[`BLR_BIT_RX_CRYPT]  = rx_block_rcvd && decrypt_busy;
      ev[`BLR_BIT_TX_CRYPT]  = tx_block_send && !encrypt_ready;
      ev[`BLR_BIT_ADV_UNDER] = adv_short;
      prev_ofs_nxt   = sched_entry_load ? sched_entry_offset : prev_ofs_r;
      entry_seen_nxt = entry_seen_r || sched_entry_load;
      // Error flags accumulate until srst clears them; no write path reaches them
      err_nxt = err_r | ev;
      // Set beats a same-cycle write-one clear
      ist_nxt = ist_r;
      if (wr && (addr == `BLR_OFS_IRQ_STAT)) begin
         ist_nxt = ist_r & ~wdata[`BLR_ERR_W-1:0];
      end
      ist_nxt = ist_nxt | ev;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         err_r        <= '0;
         ist_r        <= '0;
         prev_ofs_r   <= 1'b0;
         entry_seen_r <= 1'b0;
      end else begin
         err_r        <= err_nxt;
         ist_r        <= ist_nxt;
         prev_ofs_r   <= prev_ofs_nxt;
         entry_seen_r <= entry_seen_nxt;
      end
   end

   // Read path, data one cycle after the strobe
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (rd) begin
         unique case (addr)
            `BLR_OFS_ERR_STAT:  rdata_nxt = {21'h000000, err_r};
            `BLR_OFS_PROFILE:   rdata_nxt = prof_r;
            `BLR_OFS_IRQ_STAT:  rdata_nxt = {21'h000000, ist_r};
            `BLR_OFS_IRQ_MASK:  rdata_nxt = {21'h000000, imask_r};
            `BLR_OFS_RADIO_SEL: rdata_nxt = {11'h000, rsel_r, 16'h0000};
            `BLR_OFS_PWR_TIM:   rdata_nxt = {1'b0, rtrip_r, rxup_r, 4'h0, txdn_r, txup_r};
            `BLR_OFS_ADV_MAP:   rdata_nxt = {29'h00000000, map_r};
            `BLR_OFS_ADV_TIM:   rdata_nxt = {18'h00000, advsp_r};
            default:            rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata              = rdata_r;
   assign irq                = |(ist_r & imask_r);
   assign diag_profile       = prof_r;
   assign radio_select_field = rsel_r;
   assign round_trip_latency = rtrip_r;
   assign radio_power_en     = (rad_r != blr_pkg::RAD_IDLE);
   assign radio_tx_en        = (rad_r == blr_pkg::RAD_TX_ON);
   assign radio_rx_en        = (rad_r == blr_pkg::RAD_RX_ON);
   assign adv_slot           = slot_r;
   assign adv_channel        = `BLR_FIRST_ADV_CH + {4'h0, ch_r};
endmodule

// >>> logic/blr_defines.svh
`ifndef BLR_DEFINES_SVH
`define BLR_DEFINES_SVH

`define BLR_OFS_ERR_STAT   32'h4000_0060
`define BLR_OFS_PROFILE    32'h4000_0064
`define BLR_OFS_IRQ_STAT   32'h4000_0068
`define BLR_OFS_IRQ_MASK   32'h4000_006c
`define BLR_OFS_RADIO_SEL  32'h4000_0074
`define BLR_OFS_PWR_TIM    32'h4000_0080
`define BLR_OFS_ADV_MAP    32'h4000_0090
`define BLR_OFS_ADV_TIM    32'h4000_00a0

`define BLR_ERR_W          11
`define BLR_BIT_ADV_UNDER  10
`define BLR_BIT_GAP_UNDER  9
`define BLR_BIT_PERMIT     8
`define BLR_BIT_EVT_PF     7
`define BLR_BIT_SCH_PF     6
`define BLR_BIT_SCH_ENTRY  5
`define BLR_BIT_SCH_MEM    4
`define BLR_BIT_RAD_MEM    3
`define BLR_BIT_PKT_MEM    2
`define BLR_BIT_RX_CRYPT   1
`define BLR_BIT_TX_CRYPT   0

`define BLR_RSEL_LSB       16
`define BLR_RSEL_MSB       20
`define BLR_RTRIP_LSB      24
`define BLR_RTRIP_MSB      30
`define BLR_RXUP_LSB       16
`define BLR_RXUP_MSB       23
`define BLR_TXDN_LSB       8
`define BLR_TXDN_MSB       11
`define BLR_TXUP_LSB       0
`define BLR_TXUP_MSB       7
`define BLR_ADVSP_MSB      13
`define BLR_MAP_MSB        2

`define BLR_RST_RSEL       5'h00
`define BLR_RST_RTRIP      7'h00
`define BLR_RST_RXUP       8'hd2
`define BLR_RST_TXDN       4'h3
`define BLR_RST_TXUP       8'hd2
`define BLR_RST_MAP        3'h7
`define BLR_RST_ADVSP      14'h0000
`define BLR_FIRST_ADV_CH   6'h25

`define BLR_US_NS          1000
`define BLR_CLK_NS         50
`define BLR_US_CYC         (`BLR_US_NS / `BLR_CLK_NS)

`endif

// >>> logic/blr_pkg.sv
`include "blr_defines.svh"
package blr_pkg;
   typedef enum logic [2:0] {
      RAD_IDLE,
      RAD_TX_UP,
      RAD_TX_ON,
      RAD_TX_DN,
      RAD_RX_UP,
      RAD_RX_ON
   } blr_radio_e;
   typedef logic [`BLR_ERR_W-1:0] blr_err_t;
endpackage

// >>> logic/blr_us_timer.sv
`timescale 1ns/1ns
`include "blr_defines.svh"
module blr_us_timer #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         tick,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic              busy,
   output logic              done
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         busy_r;
   logic         busy_nxt;
   logic         done_r;
   logic         done_nxt;

   // Load restarts; a zero count finishes on the next edge
   always_comb begin
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (load) begin
         cnt_nxt  = value;
         busy_nxt = (value != '0);
         done_nxt = (value == '0);
      end else if (busy_r && tick) begin
         cnt_nxt = cnt_r - 1'b1;
         if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy = busy_r;
   assign done = done_r;
endmodule

// >>> verification/blr_regs_props.sv
`timescale 1ns/1ns
`include "blr_defines.svh"
module blr_regs_props (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        adv_enable,
   input wire logic [31:0] diag_profile,
   input wire logic [4:0]  radio_select_field,
   input wire logic [6:0]  round_trip_latency,
   input wire logic        radio_power_en,
   input wire logic        radio_tx_en,
   input wire logic        radio_rx_en,
   input wire logic        adv_slot,
   input wire logic [5:0]  adv_channel
);
   wire logic [4:0] w_sel   = wdata[20:16];
   wire logic [6:0] w_rtrip = wdata[30:24];
   wire logic       wr_prof = wr && addr == `BLR_OFS_PROFILE;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_diag_mirror: assert property (wr_prof |=> diag_profile == $past(wdata))
      else $error("profile not mirrored");
   a_diag_hold: assert property (!wr_prof |=> $stable(diag_profile))
      else $error("profile changed without write");
   a_sel_write: assert property (wr && addr == `BLR_OFS_RADIO_SEL |=> radio_select_field == $past(w_sel))
      else $error("select field not updated");
   a_rtrip_write: assert property (wr && addr == `BLR_OFS_PWR_TIM |=> round_trip_latency == $past(w_rtrip))
      else $error("round trip not updated");
   a_err_upper_zero: assert property (rd && addr == `BLR_OFS_ERR_STAT |=> rdata[31:11] == 21'h0)
      else $error("error status upper bits set");
   a_map_read_width: assert property (rd && addr == `BLR_OFS_ADV_MAP |=> rdata[31:3] == 29'h0)
      else $error("map reads wider than three bits");
   a_slot_one_cycle: assert property (adv_slot |=> !adv_slot)
      else $error("slot longer than one cycle");
   a_slot_channel: assert property (adv_slot |-> adv_channel inside {6'h25, 6'h26, 6'h27})
      else $error("slot on non advertising channel");
   a_tx_powered: assert property (radio_tx_en |-> radio_power_en && !radio_rx_en)
      else $error("tx enabled without power");
   a_rx_powered: assert property (radio_rx_en |-> radio_power_en)
      else $error("rx enabled without power");
   a_adv_off_quiet: assert property ((!adv_enable) [*2] |-> !adv_slot)
      else $error("slot while advertising off");
   c_tx_on: cover property ($rose(radio_tx_en));
   c_last_ch: cover property (adv_slot && adv_channel == 6'h27);
   c_rx_on: cover property ($rose(radio_rx_en));
endmodule

// >>> verification/blr_radio_model.sv
`timescale 1ns/1ns
module blr_radio_model (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       go,
   input  wire logic [3:0] idx,
   input  wire logic       late,
   output logic [9:0]      pulse,
   output logic [9:0]      level
);
   logic [9:0] pulse_nxt;
   logic [9:0] level_nxt;
   logic       entry_r;
   logic       entry_nxt;
   always_comb begin
      pulse_nxt = 10'h000;
      // Idle levels wander, nothing may rely on them between pulses
      level_nxt = (go | entry_r) ? 10'h000 : ~level;
      entry_nxt = 1'b0;
      if (entry_r) begin
         pulse_nxt[5] = 1'b1;
      end else if (go) begin
         pulse_nxt[idx] = 1'b1;
         level_nxt[idx] = late | (idx == 4'h5);
         entry_nxt = late & (idx == 4'h5);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         pulse   <= 10'h000;
         level   <= 10'h000;
         entry_r <= 1'b0;
      end else begin
         pulse   <= pulse_nxt;
         level   <= level_nxt;
         entry_r <= entry_nxt;
      end
   end
endmodule

// >>> verification/tb_blr_regs.sv
`timescale 1ns/1ns
`include "blr_defines.svh"
module tb_blr_regs;
   typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] q;} blr_row_s;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        go = 1'b0;
   logic [3:0]  idx = 4'h0;
   logic        late = 1'b0;
   logic        tx_start = 1'b0;
   logic        tx_end = 1'b0;
   logic        rx_start = 1'b0;
   logic        rx_end = 1'b0;
   logic        adv_enable = 1'b0;
   logic        adv_sent = 1'b0;
   logic [31:0] rdata;
   logic        irq;
   logic [9:0]  pulse;
   logic [9:0]  level;
   logic        pwr_en;
   logic        tx_en;
   logic        rx_en;
   logic        adv_slot;
   logic [5:0]  adv_ch;
   logic [31:0] exp_err;
   int          n;
   int          err_total = 0;
   int          comparisons = 0;
   blr_row_s    rows [8] = '{
      '{`BLR_OFS_PROFILE, 32'ha5a5_0ff0, 32'ha5a5_0ff0},
      '{`BLR_OFS_RADIO_SEL, 32'hffff_ffff, 32'h001f_0000},
      '{`BLR_OFS_RADIO_SEL, 32'h0002_0000, 32'h0002_0000},
      '{`BLR_OFS_PWR_TIM, 32'hffff_ffff, 32'h7fff_0fff},
      '{`BLR_OFS_ADV_MAP, 32'hffff_ffff, 32'h0000_0007},
      '{`BLR_OFS_ADV_TIM, 32'hffff_ffff, 32'h0000_3fff},
      '{`BLR_OFS_ERR_STAT, 32'hffff_ffff, 32'h0000_0000},
      '{32'h4000_0070, 32'hffff_ffff, 32'h0000_0000}};
   always #25 clk = ~clk;
   blr_regs u_dut (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .irq,
      .ifs_expire(pulse[9]), .desc_busy(level[9]), .permit_busy(level[8]), .decrypt_busy(level[1]),
      .permit_result_need(pulse[8]), .evt_prefetch_instant(pulse[7]), .evt_first_busy(level[7]),
      .sched_prefetch_instant(pulse[6]), .sched_first_busy(level[6]), .sched_entry_load(pulse[5]),
      .sched_entry_offset(level[5]), .sched_mem_deadline(pulse[4]), .sched_mem_pending(level[4]),
      .radio_mem_deadline(pulse[3]), .radio_mem_pending(level[3]), .packet_mem_deadline(pulse[2]),
      .packet_mem_pending(level[2]), .rx_block_rcvd(pulse[1]), .tx_block_send(pulse[0]),
      .encrypt_ready(~level[0]), .tx_start, .tx_end, .rx_start, .rx_end, .adv_enable,
      .adv_pkt_sent(adv_sent), .diag_profile(), .radio_select_field(), .round_trip_latency(),
      .radio_power_en(pwr_en), .radio_tx_en(tx_en), .radio_rx_en(rx_en), .adv_slot, .adv_channel(adv_ch));
   blr_radio_model u_far (.clk, .srst, .go, .idx, .late, .pulse, .level);
   task automatic summarize();
      if (err_total == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [31:0] a, input logic [31:0] q, input string nm);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(nm, rdata, q);
   endtask
   task automatic fire(input int i, input logic l);
      @(posedge clk);
      go <= 1'b1;
      idx <= 4'(i);
      late <= l;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // Bounded: a design that never answers ends the run
   task automatic wait_sig(input int w, input logic lvl, output int cnt);
      logic [3:0] v;
      cnt = 0;
      do begin
         @(posedge clk);
         #1;
         v = {adv_slot, pwr_en, rx_en, tx_en};
         cnt++;
         if (cnt > 200) begin
            err_total++;
            summarize();
         end
      end while (v[w] !== lvl);
   endtask
   task automatic send_adv(input int gap);
      repeat (gap) @(posedge clk);
      adv_sent <= 1'b1;
      @(posedge clk);
      adv_sent <= 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd_reg(`BLR_OFS_PWR_TIM, 32'h00d2_03d2, "pwr_rst");
      rd_reg(`BLR_OFS_ADV_MAP, 32'h7, "map_rst");
      rd_reg(`BLR_OFS_ERR_STAT, 32'h0, "err_rst");
      for (int r = 0; r < 8; r++) begin
         wr_reg(rows[r].a, rows[r].d);
         rd_reg(rows[r].a, rows[r].q, "row");
      end
      exp_err = 32'h0;
      for (int i = 0; i < 10; i++) begin
         wr_reg(`BLR_OFS_IRQ_MASK, ~(32'h1 << i));
         fire(i, 1'b0);
         rd_reg(`BLR_OFS_ERR_STAT, exp_err, "err_quiet");
         fire(i, 1'b1);
         exp_err |= 32'h1 << i;
         rd_reg(`BLR_OFS_ERR_STAT, exp_err, "err_set");
         check("irq_masked", {31'h0, irq}, 32'h0);
         wr_reg(`BLR_OFS_IRQ_MASK, 32'h7ff);
         #1;
         check("irq_on", {31'h0, irq}, 32'h1);
         wr_reg(`BLR_OFS_IRQ_STAT, 32'h1 << i);
         #1;
         check("irq_clr", {31'h0, irq}, 32'h0);
      end
      wr_reg(`BLR_OFS_PWR_TIM, 32'h0501_0102);
      @(posedge clk);
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      rx_start <= 1'b1;
      #1;
      check("pwr_on", {31'h0, pwr_en}, 32'h1);
      @(posedge clk);
      rx_start <= 1'b0;
      wait_sig(0, 1'b1, n);
      check("tx_up", 32'(n >= 19 && n <= 62), 32'h1);
      check("rx_refused", {31'h0, rx_en}, 32'h0);
      @(posedge clk);
      tx_end <= 1'b1;
      @(posedge clk);
      tx_end <= 1'b0;
      wait_sig(2, 1'b0, n);
      check("tx_down", 32'(n <= 42), 32'h1);
      @(posedge clk);
      rx_start <= 1'b1;
      @(posedge clk);
      rx_start <= 1'b0;
      wait_sig(1, 1'b1, n);
      check("rx_up", 32'(n <= 42), 32'h1);
      @(posedge clk);
      rx_end <= 1'b1;
      @(posedge clk);
      rx_end <= 1'b0;
      wait_sig(2, 1'b0, n);
      wr_reg(`BLR_OFS_ADV_MAP, 32'h5);
      wr_reg(`BLR_OFS_ADV_TIM, 32'h2);
      @(posedge clk);
      adv_enable <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         wait_sig(3, 1'b1, n);
         check("adv_ch", 32'(adv_ch), (k == 1) ? 32'h27 : 32'h25);
      end
      send_adv(1);
      send_adv(100);
      rd_reg(`BLR_OFS_ERR_STAT, exp_err, "adv_spaced");
      send_adv(5);
      exp_err |= 32'h400;
      rd_reg(`BLR_OFS_ERR_STAT, exp_err, "adv_under");
      @(posedge clk);
      adv_enable <= 1'b0;
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd_reg(`BLR_OFS_ERR_STAT, 32'h0, "err_rerst");
      rd_reg(`BLR_OFS_PROFILE, 32'h0, "prof_rerst");
      summarize();
   end
endmodule
bind blr_regs blr_regs_props u_props (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .adv_enable,
   .diag_profile, .radio_select_field, .round_trip_latency, .radio_power_en, .radio_tx_en,
   .radio_rx_en, .adv_slot, .adv_channel);
